// [alarm_low_power_config.sv]
`timescale 1ns/1ps
module alarm_low_power_config #(
  parameter int unsigned CYC_PER_MS = alp_pkg::CYC_PER_MS
) (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ack,
  output logic             o_reg_err,
  input  wire logic        i_role_strap,
  input  wire logic        i_switch_input,
  input  wire logic        i_bat_valid,
  input  wire logic [15:0] i_bat_mv,
  input  wire logic        i_auto_poll_on,
  input  wire logic [15:0] i_poll_time_ms,
  input  wire logic        i_sensor_req,
  input  wire logic        i_sensor_reply,
  input  wire logic        i_tx_req,
  output logic             o_switch_alarm,
  output logic             o_battery_alarm,
  output logic             o_radio_listen,
  output logic             o_preamble,
  output logic             o_tx_go,
  output logic             o_sensor_power,
  output logic             o_sensor_cmd,
  output logic             o_low_power
);
  typedef enum logic [1:0] {S_IDLE, S_WARM, S_REPLY} sensor_state_t;
  typedef enum logic [1:0] {W_IDLE, W_RX, W_PRE} wake_state_t;

  logic        rst_a_q, rst_n;
  ms_timer_if  st ();
  ms_timer_if  wt ();

  // reset release through two flops
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_a_q <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_n   <= rst_a_q;
    end
  end

  ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_sensor_tmr (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .t       (st)
  );
  ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_wake_tmr (
    .i_clock (i_clock),
    .i_rst_n (rst_n),
    .t       (wt)
  );

  // holding registers and register port
  logic [15:0] period_q, period_d, early_q, early_d, tmo_q, tmo_d;
  logic [15:0] level_q, level_d, sw_on_q, sw_on_d, src_q, src_d;
  logic [15:0] bat_on_q, bat_on_d, thr_q, thr_d, lp_on_q, lp_on_d;
  logic [15:0] rdata_d;
  logic        role_q, role_d, role_ok_q, role_ok_d;
  logic        ack_d, err_d, hit;

  always_comb
  begin
    period_d  = period_q;
    early_d   = early_q;
    tmo_d     = tmo_q;
    level_d   = level_q;
    sw_on_d   = sw_on_q;
    src_d     = src_q;
    bat_on_d  = bat_on_q;
    thr_d     = thr_q;
    lp_on_d   = lp_on_q;
    rdata_d   = 16'h0000;
    hit       = 1'b1;
    // role strap caught once, first cycle after reset release
    role_ok_d = 1'b1;
    role_d    = role_ok_q ? role_q : i_role_strap;
    case (i_reg_addr)
      alp_pkg::OFS_LISTEN_PERIOD:  rdata_d = period_q;
      alp_pkg::OFS_WAKE_ROLE:      rdata_d = {15'h0000, role_q};
      alp_pkg::OFS_SENSOR_EARLY:   rdata_d = early_q;
      alp_pkg::OFS_SENSOR_TIMEOUT: rdata_d = tmo_q;
      alp_pkg::OFS_ALARM_LEVEL:    rdata_d = level_q;
      alp_pkg::OFS_SWITCH_ALM_ON:  rdata_d = sw_on_q;
      alp_pkg::OFS_INPUT_SOURCE:   rdata_d = src_q;
      alp_pkg::OFS_BATTERY_ON:     rdata_d = bat_on_q;
      alp_pkg::OFS_BATTERY_THRESH: rdata_d = thr_q;
      alp_pkg::OFS_LOW_POWER_ON:   rdata_d = lp_on_q;
      default:                     hit     = 1'b0;
    endcase
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        alp_pkg::OFS_LISTEN_PERIOD:  period_d = i_reg_wdata;
        alp_pkg::OFS_SENSOR_EARLY:   early_d  = i_reg_wdata;
        alp_pkg::OFS_SENSOR_TIMEOUT: tmo_d    = i_reg_wdata;
        alp_pkg::OFS_ALARM_LEVEL:    level_d  = i_reg_wdata;
        alp_pkg::OFS_SWITCH_ALM_ON:  sw_on_d  = i_reg_wdata;
        alp_pkg::OFS_INPUT_SOURCE:   src_d    = i_reg_wdata;
        alp_pkg::OFS_BATTERY_ON:     bat_on_d = i_reg_wdata;
        alp_pkg::OFS_BATTERY_THRESH: thr_d    = i_reg_wdata;
        alp_pkg::OFS_LOW_POWER_ON:   lp_on_d  = i_reg_wdata;
        default:                     hit      = hit; // role write dropped
      endcase
    end
    if (!i_reg_rd)
    begin
      rdata_d = o_reg_rdata;
    end
    ack_d = i_reg_wr | i_reg_rd;
    err_d = (i_reg_wr | i_reg_rd) & ~hit;
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_q    <= alp_pkg::RST_LISTEN_PERIOD;
      early_q     <= alp_pkg::RST_ZERO;
      tmo_q       <= alp_pkg::RST_ZERO;
      level_q     <= alp_pkg::RST_ZERO;
      sw_on_q     <= alp_pkg::RST_ZERO;
      src_q       <= alp_pkg::RST_ZERO;
      bat_on_q    <= alp_pkg::RST_ZERO;
      thr_q       <= alp_pkg::RST_ZERO;
      lp_on_q     <= alp_pkg::RST_ZERO;
      role_q      <= alp_pkg::ROLE_RECEIVER;
      role_ok_q   <= 1'b0;
      o_reg_rdata <= 16'h0000;
      o_reg_ack   <= 1'b0;
      o_reg_err   <= 1'b0;
    end
    else
    begin
      period_q    <= period_d;
      early_q     <= early_d;
      tmo_q       <= tmo_d;
      level_q     <= level_d;
      sw_on_q     <= sw_on_d;
      src_q       <= src_d;
      bat_on_q    <= bat_on_d;
      thr_q       <= thr_d;
      lp_on_q     <= lp_on_d;
      role_q      <= role_d;
      role_ok_q   <= role_ok_d;
      o_reg_rdata <= rdata_d;
      o_reg_ack   <= ack_d;
      o_reg_err   <= err_d;
    end
  end

  // alarm events: switch edge and battery sample below threshold
  logic sw_prev_q, sw_prev_d, sw_alm_d, bat_alm_d, alm_en;
  always_comb
  begin
    alm_en    = (level_q != alp_pkg::RST_ZERO);
    sw_prev_d = i_switch_input;
    sw_alm_d  = 1'b0;
    if (alm_en && sw_on_q == alp_pkg::VAL_ON)
    begin
      if (src_q == alp_pkg::VAL_SRC_OPEN)
      begin
        sw_alm_d = sw_prev_q & ~i_switch_input;
      end
      else if (src_q == alp_pkg::VAL_SRC_CLOSE)
      begin
        sw_alm_d = ~sw_prev_q & i_switch_input;
      end
    end
    bat_alm_d = alm_en && bat_on_q == alp_pkg::VAL_ON && i_bat_valid
      && i_bat_mv < alp_pkg::bat_limit_mv(thr_q[3:0]);
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_prev_q       <= 1'b0;
      o_switch_alarm  <= 1'b0;
      o_battery_alarm <= 1'b0;
    end
    else
    begin
      sw_prev_q       <= sw_prev_d;
      o_switch_alarm  <= sw_alm_d;
      o_battery_alarm <= bat_alm_d;
    end
  end

  // sensor sequence: early power, command, wait reply or timeout
  sensor_state_t s_q, s_d;
  logic          pwr_d, cmd_d, lp_d;
  always_comb
  begin
    s_d        = s_q;
    pwr_d      = o_sensor_power;
    cmd_d      = 1'b0;
    st.start   = 1'b0;
    st.abort   = 1'b0;
    st.load_ms = 17'h0_0000;
    case (s_q)
      S_IDLE:
      begin
        if (i_sensor_req)
        begin
          pwr_d      = 1'b1;
          st.start   = 1'b1;
          st.load_ms = {1'b0, early_q};
          s_d        = S_WARM;
        end
      end
      S_WARM:
      begin
        if (st.done)
        begin
          cmd_d      = 1'b1;
          st.start   = 1'b1;
          st.load_ms = {1'b0, i_auto_poll_on ? i_poll_time_ms : tmo_q};
          s_d        = S_REPLY;
        end
      end
      S_REPLY:
      begin
        if (i_sensor_reply || st.done)
        begin
          st.abort = 1'b1;
          pwr_d    = 1'b0;
          s_d      = S_IDLE;
        end
      end
      default: s_d = S_IDLE;
    endcase
    lp_d = (lp_on_q == alp_pkg::VAL_ON) && (s_d == S_IDLE);
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q            <= S_IDLE;
      o_sensor_power <= 1'b0;
      o_sensor_cmd   <= 1'b0;
      o_low_power    <= 1'b0;
    end
    else
    begin
      s_q            <= s_d;
      o_sensor_power <= pwr_d;
      o_sensor_cmd   <= cmd_d;
      o_low_power    <= lp_d;
    end
  end

  // wake-on-radio: receiver listens per period, sender sends preamble
  wake_state_t w_q, w_d;
  logic        listen_d, pre_d, go_d;
  always_comb
  begin
    w_d        = w_q;
    listen_d   = 1'b0;
    pre_d      = o_preamble;
    go_d       = 1'b0;
    wt.start   = 1'b0;
    wt.abort   = 1'b0;
    wt.load_ms = alp_pkg::listen_ms(period_q[2:0]);
    case (w_q)
      W_IDLE:
      begin
        if (role_ok_q && role_q == alp_pkg::ROLE_RECEIVER)
        begin
          wt.start = 1'b1;
          w_d      = W_RX;
        end
        else if (role_ok_q && i_tx_req)
        begin
          wt.start = 1'b1;
          pre_d    = 1'b1;
          w_d      = W_PRE;
        end
      end
      W_RX:
      begin
        if (wt.done)
        begin
          listen_d = 1'b1;
          wt.start = 1'b1;
        end
      end
      W_PRE:
      begin
        if (wt.done)
        begin
          pre_d = 1'b0;
          go_d  = 1'b1;
          w_d   = W_IDLE;
        end
      end
      default: w_d = W_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_q            <= W_IDLE;
      o_radio_listen <= 1'b0;
      o_preamble     <= 1'b0;
      o_tx_go        <= 1'b0;
    end
    else
    begin
      w_q            <= w_d;
      o_radio_listen <= listen_d;
      o_preamble     <= pre_d;
      o_tx_go        <= go_d;
    end
  end
endmodule

// [alp_pkg.sv]
package alp_pkg;
  // holding register offsets (16-bit register addresses)
  localparam logic [15:0] OFS_LISTEN_PERIOD  = 16'h0B79;
  localparam logic [15:0] OFS_WAKE_ROLE      = 16'h0B80;
  localparam logic [15:0] OFS_SENSOR_EARLY   = 16'h1B5E;
  localparam logic [15:0] OFS_SENSOR_TIMEOUT = 16'h1B5F;
  localparam logic [15:0] OFS_ALARM_LEVEL    = 16'h1B60;
  localparam logic [15:0] OFS_SWITCH_ALM_ON  = 16'h1B62;
  localparam logic [15:0] OFS_INPUT_SOURCE   = 16'h1B63;
  localparam logic [15:0] OFS_BATTERY_ON     = 16'h1B64;
  localparam logic [15:0] OFS_BATTERY_THRESH = 16'h1B65;
  localparam logic [15:0] OFS_LOW_POWER_ON   = 16'h1B66;

  // reset values
  localparam logic [15:0] RST_LISTEN_PERIOD  = 16'h0003;
  localparam logic [15:0] RST_ZERO           = 16'h0000;

  // field values
  localparam logic [15:0] VAL_ON             = 16'h0001;
  localparam logic [15:0] VAL_SRC_OPEN       = 16'h0000;
  localparam logic [15:0] VAL_SRC_CLOSE      = 16'h0001;
  localparam logic       ROLE_RECEIVER      = 1'b0;

  // battery threshold: code 0 is 3450 mV, code 15 is 4200 mV
  localparam logic [15:0] BAT_BASE_MV        = 16'h0D7A; // 3450 mV
  localparam logic [15:0] BAT_STEP_MV        = 16'h0032; // 50 mV

  // timing
  localparam int unsigned LISTEN_UNIT_MS     = 500;
  localparam int unsigned CLOCK_PERIOD_NS    = 10;
  localparam int unsigned MS_IN_NS           = 1000000;
  localparam int unsigned CYC_PER_MS         = MS_IN_NS / CLOCK_PERIOD_NS;

  // listen period in ms for a 3-bit code: (1 + code) * 500
  function automatic logic [16:0] listen_ms(input logic [2:0] code);
    logic [16:0] n;
    n = 17'({14'h0, code} + 17'd1);
    return 17'(n * 17'(LISTEN_UNIT_MS));
  endfunction

  // battery threshold in mV for a 4-bit code
  function automatic logic [15:0] bat_limit_mv(input logic [3:0] code);
    return 16'(BAT_BASE_MV + 16'({12'h000, code} * BAT_STEP_MV));
  endfunction
endpackage

// [ms_timer_if.sv]
`timescale 1ns/1ps
interface ms_timer_if;
  logic        start;
  logic        abort;
  logic [16:0] load_ms;
  logic        done;
  logic        busy;
  modport ctrl (output start, abort, load_ms, input done, busy);
  modport tmr  (input start, abort, load_ms, output done, busy);
endinterface

// [ms_timer.sv]
`timescale 1ns/1ps
// millisecond down-counter; done pulses once load_ms whole ms have passed
module ms_timer #(
  parameter int unsigned CYC_PER_MS = alp_pkg::CYC_PER_MS
) (
  input  wire logic  i_clock,
  input  wire logic  i_rst_n,
  ms_timer_if.tmr    t
);
  logic        run_q,  run_d;
  logic        done_q, done_d;
  logic [16:0] left_q, left_d;
  logic [31:0] pre_q,  pre_d;

  // next-state: start reloads, abort stops without done
  always_comb
  begin
    run_d  = run_q;
    left_d = left_q;
    pre_d  = pre_q;
    done_d = 1'b0;
    if (t.start)
    begin
      run_d  = 1'b1;
      left_d = t.load_ms;
      pre_d  = 32'h0000_0000;
    end
    else if (t.abort)
    begin
      run_d = 1'b0;
    end
    else if (run_q)
    begin
      if (left_q == 17'h0_0000)
      begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
      else if (pre_q == 32'(CYC_PER_MS - 1))
      begin
        pre_d  = 32'h0000_0000;
        left_d = 17'(left_q - 17'h0_0001);
      end
      else
      begin
        pre_d = 32'(pre_q + 32'h0000_0001);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_q  <= 1'b0;
      done_q <= 1'b0;
      left_q <= 17'h0_0000;
      pre_q  <= 32'h0000_0000;
    end
    else
    begin
      run_q  <= run_d;
      done_q <= done_d;
      left_q <= left_d;
      pre_q  <= pre_d;
    end
  end

  assign t.done = done_q;
  assign t.busy = run_q;
endmodule

// [alarm_low_power_config_sva.sv]
`timescale 1ns/1ps
// watches the register port and the event outputs of the config block
module alarm_low_power_config_sva (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic        o_reg_ack,
  input wire logic        o_reg_err,
  input wire logic        i_switch_input,
  input wire logic        i_bat_valid,
  input wire logic        i_sensor_req,
  input wire logic        i_sensor_reply,
  input wire logic        o_switch_alarm,
  input wire logic        o_battery_alarm,
  input wire logic        o_preamble,
  input wire logic        o_tx_go,
  input wire logic        o_sensor_power,
  input wire logic        o_sensor_cmd,
  input wire logic        o_low_power
);
  logic wait_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // high from the sensor command until the supply drops
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      wait_q <= 1'b0;
    else
      wait_q <= o_sensor_power && (wait_q || o_sensor_cmd);

  property p_ack;
    i_reg_wr || i_reg_rd |=> o_reg_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("access without acknowledge");
  property p_role;
    i_reg_wr && i_reg_addr == alp_pkg::OFS_WAKE_ROLE |=> !o_reg_err;
  endproperty
  a_role: assert property (p_role)
    else $error("role write flagged as error");
  property p_pwr;
    i_sensor_req && !o_sensor_power |=> o_sensor_power;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("sensor supply not switched on");
  property p_reply;
    wait_q && i_sensor_reply |=> !o_sensor_power;
  endproperty
  a_reply: assert property (p_reply)
    else $error("supply kept on after reply");
  property p_low;
    o_sensor_power |-> !o_low_power;
  endproperty
  a_low: assert property (p_low)
    else $error("low power during sensor access");
  property p_txgo;
    o_tx_go |-> $fell(o_preamble);
  endproperty
  a_txgo: assert property (p_txgo)
    else $error("packet sent without preamble end");
  property p_bat;
    o_battery_alarm |-> $past(i_bat_valid);
  endproperty
  a_bat: assert property (p_bat)
    else $error("battery alarm without sample");
  property p_sw;
    o_switch_alarm |-> $past(i_switch_input, 1) != $past(i_switch_input, 2);
  endproperty
  a_sw: assert property (p_sw)
    else $error("switch alarm without input change");
endmodule

bind alarm_low_power_config alarm_low_power_config_sva u_sva (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_ack(o_reg_ack),
  .o_reg_err(o_reg_err), .i_switch_input(i_switch_input),
  .i_bat_valid(i_bat_valid), .i_sensor_req(i_sensor_req),
  .i_sensor_reply(i_sensor_reply), .o_switch_alarm(o_switch_alarm),
  .o_battery_alarm(o_battery_alarm), .o_preamble(o_preamble),
  .o_tx_go(o_tx_go), .o_sensor_power(o_sensor_power),
  .o_sensor_cmd(o_sensor_cmd), .o_low_power(o_low_power)
);

// [sensor_responder.sv]
`timescale 1ns/1ps
// sensor on the far side; muted it ignores new commands, a pending reply still comes
module sensor_responder #(
  parameter int DELAY = 5
) (
  input  wire logic i_clock,
  input  wire logic i_cmd,
  input  wire logic i_answer_on,
  output logic      o_reply
);
  int wait_left = 0;

  initial o_reply = 1'b0;
  // one reply pulse DELAY cycles after each command
  always @(negedge i_clock)
  begin
    o_reply <= (wait_left == 1);
    if (i_cmd === 1'b1 && i_answer_on)
      wait_left <= DELAY;
    else if (wait_left > 0)
      wait_left <= wait_left - 1;
  end
endmodule

// [alarm_low_power_config_tb.sv]
`timescale 1ns/1ps
module alarm_low_power_config_tb;
  localparam int CYC = 10; // one ms is shortened to ten cycles
  logic        i_clock, i_nrst, i_reg_wr, i_reg_rd, i_role_strap;
  logic        i_switch_input, i_bat_valid, i_auto_poll_on;
  logic        i_sensor_req, i_sensor_reply, i_tx_req, answer_on;
  logic [15:0] i_reg_addr, i_reg_wdata, i_bat_mv, i_poll_time_ms;
  logic [15:0] o_reg_rdata;
  logic        o_reg_ack, o_reg_err, o_switch_alarm, o_battery_alarm;
  logic        o_radio_listen, o_preamble, o_tx_go, o_sensor_power;
  logic        o_sensor_cmd, o_low_power, pwr_q;
  int          num_errors, samples_checked, cyc, n_sw, n_bat;
  int          t_cmd, t_off, t_go, t_tx, t_rel, t_rx1, t_rx2;

  alarm_low_power_config #(.CYC_PER_MS(CYC)) u_dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err),
    .i_role_strap(i_role_strap), .i_switch_input(i_switch_input),
    .i_bat_valid(i_bat_valid), .i_bat_mv(i_bat_mv),
    .i_auto_poll_on(i_auto_poll_on), .i_poll_time_ms(i_poll_time_ms),
    .i_sensor_req(i_sensor_req), .i_sensor_reply(i_sensor_reply),
    .i_tx_req(i_tx_req), .o_switch_alarm(o_switch_alarm),
    .o_battery_alarm(o_battery_alarm), .o_radio_listen(o_radio_listen),
    .o_preamble(o_preamble), .o_tx_go(o_tx_go),
    .o_sensor_power(o_sensor_power), .o_sensor_cmd(o_sensor_cmd),
    .o_low_power(o_low_power)
  );

  sensor_responder #(.DELAY(5)) u_sensor (
    .i_clock(i_clock), .i_cmd(o_sensor_cmd), .i_answer_on(answer_on),
    .o_reply(i_sensor_reply)
  );

  // free running clock
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // event log per rising edge; also cuts a hang short
  always @(posedge i_clock)
  begin
    cyc++;
    n_sw += int'(o_switch_alarm === 1'b1);
    n_bat += int'(o_battery_alarm === 1'b1);
    if (o_sensor_cmd === 1'b1)
      t_cmd = cyc;
    if (pwr_q === 1'b1 && o_sensor_power === 1'b0)
      t_off = cyc;
    if (o_tx_go === 1'b1)
      t_go = cyc;
    if (o_radio_listen === 1'b1 && t_rx1 == 0)
      t_rx1 = cyc;
    else if (o_radio_listen === 1'b1 && t_rx2 == 0)
      t_rx2 = cyc;
    pwr_q = o_sensor_power;
    if (cyc == 40000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one register access; ack, err and data are looked at in their cycle
  task automatic acc(input logic w, input logic [15:0] a, d, exp,
                     input logic err);
    @(negedge i_clock);
    i_reg_wr    = w;
    i_reg_rd    = !w;
    i_reg_addr  = a;
    i_reg_wdata = d;
    @(negedge i_clock);
    chk({15'h0, o_reg_ack}, 16'h0001);
    chk({15'h0, o_reg_err}, {15'h0, err});
    if (!w)
      chk(o_reg_rdata, exp);
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
  endtask

  // battery sample, then time for the alarm to land
  task automatic bat(input logic [15:0] mv, input int n);
    @(negedge i_clock);
    i_bat_mv    = mv;
    i_bat_valid = 1'b1;
    @(negedge i_clock);
    i_bat_valid = 1'b0;
    repeat (4) @(negedge i_clock);
    chk(16'(n_bat), 16'(n));
  endtask

  task automatic sw(input logic v, input int n);
    @(negedge i_clock);
    i_switch_input = v;
    repeat (6) @(negedge i_clock);
    chk(16'(n_sw), 16'(n));
  endtask

  // one sensor access; lo_cmd and lo_off are the lower time bounds
  task automatic sense(input int lo_cmd, lo_off);
    int t0;
    @(negedge i_clock);
    i_sensor_req = 1'b1;
    t0 = cyc + 1;
    @(negedge i_clock);
    i_sensor_req = 1'b0;
    for (int k = 0; k < 400 && o_sensor_power !== 1'b0; k++)
      @(negedge i_clock);
    // one more edge so the log has caught the supply drop
    @(negedge i_clock);
    chk(16'(t_cmd - t0 >= lo_cmd && t_cmd - t0 <= lo_cmd + 5), 16'h0001);
    chk(16'(t_off - t_cmd >= lo_off && t_off - t_cmd <= lo_off + 4),
        16'h0001);
    chk({15'h0, o_low_power}, 16'h0001);
  endtask

  // main sequence
  initial
  begin
    {i_nrst, i_reg_wr, i_reg_rd, i_switch_input, i_bat_valid} = '0;
    {i_auto_poll_on, i_sensor_req, i_tx_req} = '0;
    {i_reg_addr, i_reg_wdata, i_bat_mv} = '0;
    i_poll_time_ms = 16'h0001;
    i_role_strap   = 1'b1;
    answer_on      = 1'b1;
    repeat (6) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clock);
    acc(0, alp_pkg::OFS_LISTEN_PERIOD, 0, 16'h0003, 0);
    for (logic [15:0] a = 16'h1b5e; a <= 16'h1b66; a++)
      if (a != 16'h1b61)
        acc(0, a, 0, 16'h0000, 0);
    acc(0, alp_pkg::OFS_WAKE_ROLE, 0, 16'h0001, 0);
    acc(1, alp_pkg::OFS_WAKE_ROLE, 16'h0000, 0, 0);
    acc(0, alp_pkg::OFS_WAKE_ROLE, 0, 16'h0001, 0);
    acc(0, 16'h0000, 0, 16'h0000, 1);
    acc(1, alp_pkg::OFS_SENSOR_EARLY, 16'ha5c3, 0, 0);
    acc(0, alp_pkg::OFS_SENSOR_EARLY, 0, 16'ha5c3, 0);
    acc(1, alp_pkg::OFS_SWITCH_ALM_ON, 16'h0001, 0, 0);
    acc(1, alp_pkg::OFS_BATTERY_ON, 16'h0001, 0, 0);
    acc(1, alp_pkg::OFS_BATTERY_THRESH, 16'h0004, 0, 0);
    sw(1, 0);
    bat(16'd3000, 0);
    acc(1, alp_pkg::OFS_ALARM_LEVEL, 16'h0001, 0, 0);
    bat(16'd3600, 1);
    bat(16'd3700, 1);
    acc(1, alp_pkg::OFS_BATTERY_THRESH, 16'h000f, 0, 0);
    bat(16'd4150, 2);
    sw(0, 1);
    sw(1, 1);
    acc(1, alp_pkg::OFS_INPUT_SOURCE, 16'h0001, 0, 0);
    sw(0, 1);
    sw(1, 2);
    acc(1, alp_pkg::OFS_BATTERY_ON, 16'h0000, 0, 0);
    bat(16'd3000, 2);
    acc(1, alp_pkg::OFS_SENSOR_EARLY, 16'h0002, 0, 0);
    acc(1, alp_pkg::OFS_SENSOR_TIMEOUT, 16'h0003, 0, 0);
    acc(1, alp_pkg::OFS_LOW_POWER_ON, 16'h0001, 0, 0);
    sense(2 * CYC, 5);
    answer_on = 1'b0;
    sense(2 * CYC, 3 * CYC);
    i_auto_poll_on = 1'b1;
    sense(2 * CYC, 1 * CYC);
    acc(1, alp_pkg::OFS_LISTEN_PERIOD, 16'h0000, 0, 0);
    @(negedge i_clock);
    i_tx_req = 1'b1;
    t_tx = cyc + 1;
    @(negedge i_clock);
    i_tx_req = 1'b0;
    @(negedge i_clock);
    chk({15'h0, o_preamble}, 16'h0001);
    for (int k = 0; k < 6000 && t_go == 0; k++)
      @(negedge i_clock);
    chk(16'(t_go - t_tx >= 500 * CYC && t_go - t_tx <= 500 * CYC + 6),
        16'h0001);
    // mid-run reset; the strap now selects the receiver role
    @(negedge i_clock);
    i_nrst       = 1'b0;
    i_role_strap = 1'b0;
    repeat (6) @(negedge i_clock);
    i_nrst = 1'b1;
    t_rel  = cyc + 1;
    repeat (4) @(negedge i_clock);
    acc(0, alp_pkg::OFS_WAKE_ROLE, 0, 16'h0000, 0);
    acc(0, alp_pkg::OFS_LISTEN_PERIOD, 0, 16'h0003, 0);
    acc(1, alp_pkg::OFS_LISTEN_PERIOD, 16'h0000, 0, 0);
    // first slot runs on the reset period, the next on code 0
    for (int k = 0; k < 26000 && t_rx2 == 0; k++)
      @(negedge i_clock);
    chk(16'(t_rx1 - t_rel >= 2000 * CYC && t_rx1 - t_rel <= 2000 * CYC + 9),
        16'h0001);
    chk(16'(t_rx2 - t_rx1 >= 500 * CYC && t_rx2 - t_rx1 <= 500 * CYC + 6),
        16'h0001);
    end_of_test();
  end
endmodule
